// ==== dv/sram_ctrl_properties.sv ====
`default_nettype none
`include "sram_ctrl_cfg.svh"
module sram_ctrl_properties (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic mem_sel_n,
	input wire logic mem_wstrobe_n,
	input wire logic mem_drive_n,
	input wire logic [`ADDR_W-1:0] mem_addr,
	input wire logic [`DATA_W-1:0] mem_dq_out,
	input wire logic mem_dq_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Pin timing in whole clock cycles.
	// ****
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	rd_strobe_a: assert property (
		!mem_drive_n |-> mem_wstrobe_n)
		else $error("strobe low in read");
	no_contend_a: assert property (
		mem_dq_oe |-> mem_drive_n)
		else $error("bus contention");
	wr_pins_a: assert property (
		!mem_wstrobe_n |-> !mem_sel_n && mem_dq_oe)
		else $error("write without select or data");
	wr_hold_a: assert property (!mem_wstrobe_n |=>
		$stable(mem_dq_out) && $stable(mem_addr))
		else $error("data or address moved");
	joint_end_a: assert property (
		$rose(mem_wstrobe_n) |-> $rose(mem_sel_n))
		else $error("strobes not released together");
	wr_pulse_a: assert property (
		$fell(mem_wstrobe_n) |-> !mem_wstrobe_n [*2])
		else $error("write pulse short");
	float_gap_a: assert property (
		$rose(mem_drive_n) |-> !mem_dq_oe [*2])
		else $error("drive before memory floats");
	rd_answer_a: assert property (req_valid && req_ready && !req_write
		|-> ##5 rsp_valid)
		else $error("read answer late");
	rsp_pulse_a: assert property (
		rsp_valid |=> !rsp_valid)
		else $error("read answer longer than one cycle");
	idle_desel_a: assert property (
		req_ready |-> mem_sel_n && mem_drive_n && mem_wstrobe_n)
		else $error("memory selected while idle");
	cover property (rsp_valid);
	cover property ($fell(mem_wstrobe_n));
	cover property ($rose(mem_drive_n) ##[1:8] mem_dq_oe);
endmodule
`default_nettype wire

// ==== dv/sram_ctrl_tb.sv ====
`default_nettype none
`include "sram_ctrl_cfg.svh"
module sram_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [`ADDR_W-1:0] req_addr = 19'h0;
	logic [`DATA_W-1:0] req_wdata = 8'h0;
	logic req_ready, rsp_valid, sel_n, ws_n, dr_n, oe;
	logic [`DATA_W-1:0] rdata, dout, m_dq;
	logic [`ADDR_W-1:0] maddr;
	wire logic [`DATA_W-1:0] bus = oe ? dout : m_dq;
	int err_total = 0;
	int n_checks = 0;
	always #12.5 ref_clk = ~ref_clk;
	sram_ctrl uut (.ref_clk, .sys_rst, .req_valid, .req_write, .req_addr,
		.req_wdata, .req_ready, .rsp_valid, .rsp_rdata(rdata),
		.mem_sel_n(sel_n), .mem_wstrobe_n(ws_n), .mem_drive_n(dr_n),
		.mem_addr(maddr), .mem_dq_in(bus), .mem_dq_out(dout),
		.mem_dq_oe(oe));
	sram_model mem_i (.sel_n, .wstrobe_n(ws_n), .drive_n(dr_n),
		.addr(maddr), .din(bus), .dq(m_dq), .dq_oe());
	// ****
	// Requests, checks and scenarios.
	// ****
	task automatic results();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic access(input logic w, input logic [18:0] a,
		input logic [7:0] d);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		do @(posedge ref_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
	endtask
	task automatic rd(input logic [18:0] a, input logic [7:0] exp);
		access(1'b0, a, 8'h00);
		do @(posedge ref_clk); while (rsp_valid !== 1'b1);
		chk("read data", exp, rdata);
		@(posedge ref_clk);
		chk("read pulse", 8'h00, {7'h0, rsp_valid});
	endtask
	task automatic t_edges();
		access(1'b1, 19'h00000, 8'hA5);
		access(1'b1, 19'h7FFFF, 8'h5A);
		rd(19'h00000, 8'hA5);
		rd(19'h7FFFF, 8'h5A);
	endtask
	task automatic t_turn();
		access(1'b1, 19'h2AAAA, 8'h0F);
		access(1'b1, 19'h2AAAA, 8'hF0);
		rd(19'h2AAAA, 8'hF0);
		access(1'b1, 19'h55555, 8'h3C);
		chk("held data", 8'hF0, rdata);
		rd(19'h55555, 8'h3C);
		rd(19'h2AAAA, 8'hF0);
	endtask
	// A reset in mid-write must leave idle pins and a working sequencer.
	task automatic t_reset();
		access(1'b1, 19'h12345, 8'hC3);
		sys_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		chk("reset pins", 8'h2E,
			{2'h0, req_ready, rsp_valid, sel_n, ws_n, dr_n, oe});
		rd(19'h2AAAA, 8'hF0);
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		chk("idle pins", 8'h2E,
			{2'h0, req_ready, rsp_valid, sel_n, ws_n, dr_n, oe});
		t_edges();
		t_turn();
		t_reset();
		results();
	end
	initial begin
		#75000;
		err_total++;
		results();
	end
endmodule
bind sram_ctrl sram_ctrl_properties chk_i (.ref_clk, .sys_rst, .req_valid,
	.req_write, .req_ready, .rsp_valid, .mem_sel_n, .mem_wstrobe_n,
	.mem_drive_n, .mem_addr, .mem_dq_out, .mem_dq_oe);
`default_nettype wire

// ==== dv/sram_model.sv ====
`default_nettype none
`include "sram_ctrl_cfg.svh"
module sram_model #(
	parameter int ACC_NS = 45,
	parameter int OFF_NS = 18,
	parameter int PD_NS = 45
) (
	input wire logic sel_n,
	input wire logic wstrobe_n,
	input wire logic drive_n,
	input wire logic [`ADDR_W-1:0] addr,
	input wire logic [`DATA_W-1:0] din,
	output logic [`DATA_W-1:0] dq,
	output logic dq_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Byte array with delayed drive.
	// ****
	logic [`DATA_W-1:0] mem [int];
	logic [`DATA_W-1:0] q = 8'h00;
	logic on = 1'b0;
	logic asleep = 1'b1;
	wire logic wr_on = !sel_n && !wstrobe_n;
	wire logic rd_on = !sel_n && !drive_n && wstrobe_n;
	always @(negedge wr_on) mem[addr] = din;
	always @(rd_on)
		on <= #((rd_on === 1'b1) ? ACC_NS : OFF_NS) (rd_on === 1'b1);
	// Deselect powers the array down late; select wakes it at once.
	always @(sel_n)
		asleep <= #((sel_n === 1'b1) ? PD_NS : 0) (sel_n !== 1'b0);
	always @(addr or posedge rd_on)
		q <= #ACC_NS (mem.exists(addr) ? mem[addr] : 8'h00);
	// Released pins show the inverse byte so a stale value never passes.
	assign dq = (on && !asleep) ? q : ~q;
	assign dq_oe = on;
endmodule
`default_nettype wire

// ==== hw/dq_sync.sv ====
`default_nettype none
`include "sram_ctrl_cfg.svh"
module dq_sync #(
	parameter int WIDTH = `DATA_W
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] dq_pin,
	output logic [WIDTH-1:0] dq_q
);
	// Two stages: the read word is sampled long after it settled, the
	// second stage only guards against a late edge.
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;
	always_comb begin
		meta_next = sys_rst ? '0 : dq_pin;
		sync_next = sys_rst ? '0 : meta_reg;
	end
	always_ff @(posedge ref_clk) begin
		meta_reg <= meta_next;
		sync_reg <= sync_next;
	end
	assign dq_q = sync_reg;
endmodule
`default_nettype wire

// ==== hw/sram_ctrl.sv ====
// Contract
// - Data stable 25 ns before write end.
// - Address held over write; 35 ns overlap.
// - Strobe pulse covers setup plus float.
// - Write strobe stays high during reads.
// - Controller never drives while memory drives.
`default_nettype none
`include "sram_ctrl_cfg.svh"
module sram_ctrl
	import sram_ctrl_pkg::*;
#(
	parameter int READ_WAIT = `READ_WAIT_CYC,
	parameter int WRITE_PULSE = `WRITE_PULSE_CYC,
	parameter int FLOAT_WAIT = `FLOAT_WAIT_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [`ADDR_W-1:0] req_addr,
	input wire logic [`DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [`DATA_W-1:0] rsp_rdata,
	output logic mem_sel_n,
	output logic mem_wstrobe_n,
	output logic mem_drive_n,
	output logic [`ADDR_W-1:0] mem_addr,
	input wire logic [`DATA_W-1:0] mem_dq_in,
	output logic [`DATA_W-1:0] mem_dq_out,
	output logic mem_dq_oe
);
	import sram_ctrl_pkg::*;

	// ****************************************************************
	// Pin carrier and input synchroniser.
	// ****************************************************************
	sram_pins_if pins ();

	dq_sync #(.WIDTH(`DATA_W)) u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.dq_pin(mem_dq_in),
		.dq_q(pins.dq_sync)
	);

	// ****************************************************************
	// Sequencer. The read wait, write pulse and float wait are cycle counts derived from
	// the nanosecond constants, so a faster clock only needs new
	// counts; the two synchroniser cycles and the write end cycle are fixed.
	// ****************************************************************
	ctrl_state_t state_reg, state_next;
	logic [`CNT_W-1:0] cnt_reg, cnt_next;
	logic sel_n_reg, sel_n_next;
	logic we_n_reg, we_n_next;
	logic oe_n_reg, oe_n_next;
	logic dq_oe_reg, dq_oe_next;
	logic [`ADDR_W-1:0] addr_reg, addr_next;
	logic [`DATA_W-1:0] wdata_reg, wdata_next;
	logic [`DATA_W-1:0] rdata_reg, rdata_next;
	logic ready_reg, ready_next;
	logic rsp_reg, rsp_next;

	// ****************************************************************
	// Next-state logic.
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		sel_n_next = sel_n_reg;
		we_n_next = we_n_reg;
		oe_n_next = oe_n_reg;
		dq_oe_next = dq_oe_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		ready_next = ready_reg;
		rsp_next = 1'b0;
		unique case (state_reg)
		ST_IDLE: begin
			// Deselected between accesses so the memory can power down.
			sel_n_next = 1'b1;
			we_n_next = 1'b1;
			oe_n_next = 1'b1;
			// A request while busy is not taken; the host holds it up.
			if (req_valid && ready_reg) begin
				ready_next = 1'b0;
				addr_next = req_addr;
				sel_n_next = 1'b0;
				cnt_next = '0;
				if (req_write) begin
					// Drive starts as the strobe falls: the memory floats at
					// once because drive stays high throughout a write.
					wdata_next = req_wdata;
					we_n_next = 1'b0;
					dq_oe_next = 1'b1;
					state_next = ST_WR_PULSE;
				end else begin
					we_n_next = 1'b1;
					oe_n_next = 1'b0;
					state_next = ST_RD_WAIT;
				end
			end
		end
		ST_RD_WAIT: begin
			cnt_next = cnt_reg + 1'b1;
			// Two extra cycles let the word pass the synchroniser.
			// That latency is the price of never sampling a data pin that
			// may still be settling.
			if (32'(cnt_reg) == READ_WAIT + 1) begin
				rdata_next = pins.dq_sync;
				rsp_next = 1'b1;
				oe_n_next = 1'b1;
				sel_n_next = 1'b1;
				cnt_next = '0;
				state_next = ST_RD_FLOAT;
			end
		end
		ST_RD_FLOAT: begin
			// No one drives until the memory has surely floated.
			cnt_next = cnt_reg + 1'b1;
			if (32'(cnt_reg) == FLOAT_WAIT - 1) begin
				ready_next = 1'b1;
				state_next = ST_IDLE;
			end
		end
		ST_WR_PULSE: begin
			cnt_next = cnt_reg + 1'b1;
			if (32'(cnt_reg) == WRITE_PULSE - 1) begin
				// Both strobes rise together; data and address hold past.
				we_n_next = 1'b1;
				sel_n_next = 1'b1;
				state_next = ST_WR_END;
			end
		end
		ST_WR_END: begin
			// The driver lets go one cycle after the strobes rise, which
			// gives the memory a whole cycle of data hold.
			dq_oe_next = 1'b0;
			ready_next = 1'b1;
			state_next = ST_IDLE;
		end
		default: begin
			// An illegal code returns to idle; the three strobes follow one edge later, while dq_oe and ready keep their values.
			state_next = ST_IDLE;
		end
		endcase
		// A reset in mid-write cuts the pulse short, so the byte at that
		// address is undefined afterwards.
		if (sys_rst) begin
			state_next = ST_IDLE;
			cnt_next = '0;
			sel_n_next = 1'b1;
			we_n_next = 1'b1;
			oe_n_next = 1'b1;
			dq_oe_next = 1'b0;
			addr_next = '0;
			wdata_next = '0;
			rdata_next = '0;
			ready_next = 1'b1;
			rsp_next = 1'b0;
		end
	end

	// ****************************************************************
	// State registers.
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		state_reg <= state_next;
		cnt_reg <= cnt_next;
		sel_n_reg <= sel_n_next;
		we_n_reg <= we_n_next;
		oe_n_reg <= oe_n_next;
		dq_oe_reg <= dq_oe_next;
		addr_reg <= addr_next;
		wdata_reg <= wdata_next;
		rdata_reg <= rdata_next;
		ready_reg <= ready_next;
		rsp_reg <= rsp_next;
	end

	// ****************************************************************
	// Pin outputs.
	// ****************************************************************
	// Each pin comes straight from a register, so no decode glitch can
	// ever reach a strobe.
	assign pins.sel_n = sel_n_reg;
	assign pins.wstrobe_n = we_n_reg;
	assign pins.drive_n = oe_n_reg;
	assign pins.addr = addr_reg;
	assign pins.dq_out = wdata_reg;
	assign pins.dq_oe = dq_oe_reg;

	assign mem_sel_n = pins.sel_n;
	assign mem_wstrobe_n = pins.wstrobe_n;
	assign mem_drive_n = pins.drive_n;
	assign mem_addr = pins.addr;
	assign mem_dq_out = pins.dq_out;
	assign mem_dq_oe = pins.dq_oe;

	// ****************************************************************
	// Host side.
	// ****************************************************************
	// The answer is registered; on a read it lands four edges after the take.
	assign req_ready = ready_reg;
	assign rsp_valid = rsp_reg;
	assign rsp_rdata = rdata_reg;
endmodule
`default_nettype wire

// ==== hw/sram_ctrl_cfg.svh ====
`ifndef SRAM_CTRL_CFG_SVH
`define SRAM_CTRL_CFG_SVH
// ****************************************************************
// Timing of the memory, in nanoseconds, and the clock period.
// ****************************************************************
`define CLK_PERIOD_NS 25
`define READ_CYCLE_MIN_NS 45
`define ADDR_TO_DATA_DELAY_NS 45
`define DRIVE_TURN_OFF_NS 18
`define WRITE_CYCLE_MIN_NS 45
`define ADDR_SETUP_TO_END_NS 35
`define WRITE_PULSE_MIN_NS 35
`define DATA_SETUP_TO_END_NS 25
`define STROBE_LOW_FLOAT_NS 18
`define DESELECT_POWER_DOWN_NS 45
// ****************************************************************
// Derived cycle counts: least times round up.
// ****************************************************************
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC `CEIL_CYC(`ADDR_TO_DATA_DELAY_NS)
`define WRITE_PULSE_CYC `CEIL_CYC(`WRITE_PULSE_MIN_NS)
`define FLOAT_WAIT_CYC `CEIL_CYC(`DRIVE_TURN_OFF_NS)
`define ADDR_W 19
`define DATA_W 8
`define CNT_W 4
`endif

// ==== hw/sram_ctrl_pkg.sv ====
`default_nettype none
package sram_ctrl_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RD_WAIT = 3'h1,
		ST_RD_FLOAT = 3'h3,
		ST_WR_PULSE = 3'h2,
		ST_WR_END = 3'h6
	} ctrl_state_t;
endpackage
`default_nettype wire

// ==== hw/sram_pins_if.sv ====
`default_nettype none
`include "sram_ctrl_cfg.svh"
interface sram_pins_if;
	logic sel_n;
	logic wstrobe_n;
	logic drive_n;
	logic [`ADDR_W-1:0] addr;
	logic [`DATA_W-1:0] dq_out;
	logic dq_oe;
	logic [`DATA_W-1:0] dq_sync;
	modport ctrl (output sel_n, wstrobe_n, drive_n, addr, dq_out, dq_oe,
		input dq_sync);
	modport pins (input sel_n, wstrobe_n, drive_n, addr, dq_out, dq_oe,
		output dq_sync);
endinterface
`default_nettype wire
